// ---- verif/test_waveform_template_ram_access.sv ----
// Self-checking AXI4-Lite testbench for the waveform template RAM access block.
`timescale 1ns/100ps
module test_waveform_template_ram_access;
    import wavram_pkg::*;

    logic              clk_i;
    logic              rst_i;
    logic [ADDR_W-1:0] awaddr_i;
    logic              awvalid_i;
    logic              awready_o;
    logic [31:0]       wdata_i;
    logic [3:0]        wstrb_i;
    logic              wvalid_i;
    logic              wready_o;
    logic [1:0]        bresp_o;
    logic              bvalid_o;
    logic              bready_i;
    logic [ADDR_W-1:0] araddr_i;
    logic              arvalid_i;
    logic              arready_o;
    logic [31:0]       rdata_o;
    logic [1:0]        rresp_o;
    logic              rvalid_o;
    logic              rready_i;
    int                failures;
    int                n_tests;

    waveform_template_ram_access i_waveform_template_ram_access (
        .clk_i(clk_i), .rst_i(rst_i),
        .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
        .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
        .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
        .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
        .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Byte address of a register: channel block index plus register index, times four.
    function automatic logic [ADDR_W-1:0] ra(input int ch, input logic [5:0] off);
        logic [10:0] idx;
        idx = (ch == 0) ? 11'h7c0 : 11'((ch - 1) * 64);
        idx = idx + {5'h00, off};
        return {idx, 2'b00};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Address and data are offered together; each is dropped at the edge it is taken.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
        int  n;
        bit  ad;
        bit  wd;
        bit  dn;
        n  = 0;
        ad = 0;
        wd = 0;
        dn = 0;
        @(posedge clk_i);
        awaddr_i  <= a;
        awvalid_i <= 1'b1;
        wdata_i   <= {24'h000000, d};
        wstrb_i   <= 4'h1;
        wvalid_i  <= 1'b1;
        bready_i  <= 1'b1;
        while (n < 200) begin
            @(posedge clk_i);
            n++;
            if (awvalid_i && awready_o === 1'b1) begin
                ad = 1;
                awvalid_i <= 1'b0;
            end
            if (wvalid_i && wready_o === 1'b1) begin
                wd = 1;
                wvalid_i <= 1'b0;
            end
            if (ad && wd && bvalid_o === 1'b1) begin
                bready_i <= 1'b0;
                check({30'h0, bresp_o}, {30'h0, er});
                dn = 1;
                break;
            end
        end
        if (!dn) begin
            failures++;
            $display("Error at %0t: write to %h hung, got %h expected %h", $time, a, 0, 1);
        end
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] ed, input logic [1:0] er);
        int n;
        bit ad;
        bit dn;
        n  = 0;
        ad = 0;
        dn = 0;
        @(posedge clk_i);
        araddr_i  <= a;
        arvalid_i <= 1'b1;
        rready_i  <= 1'b1;
        while (n < 200) begin
            @(posedge clk_i);
            n++;
            if (arvalid_i && arready_o === 1'b1) begin
                ad = 1;
                arvalid_i <= 1'b0;
            end
            if (ad && rvalid_o === 1'b1) begin
                rready_i <= 1'b0;
                check(rdata_o, {24'h000000, ed});
                check({30'h0, rresp_o}, {30'h0, er});
                dn = 1;
                break;
            end
        end
        if (!dn) begin
            failures++;
            $display("Error at %0t: read of %h hung, got %h expected %h", $time, a, 0, 1);
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        $display("Error at %0t: watchdog expired, got %h expected %h", $time, 0, 1);
        print_verdict();
    end

    initial begin
        int chs[3];
        failures  = 0;
        n_tests   = 0;
        rst_i     = 1'b1;
        awaddr_i  = '0;
        awvalid_i = 1'b0;
        wdata_i   = '0;
        wstrb_i   = '0;
        wvalid_i  = 1'b0;
        bready_i  = 1'b0;
        araddr_i  = '0;
        arvalid_i = 1'b0;
        rready_i  = 1'b0;
        chs       = '{0, 1, 15};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);

        foreach (chs[i]) begin
            rd(ra(chs[i], OFF_CTRL), 8'h00, RESP_OKAY);
            rd(ra(chs[i], OFF_SAMPLE), 8'h00, RESP_OKAY);
            rd(ra(chs[i], OFF_PULSE), 8'h02, RESP_OKAY);
        end
        $display("Test reset_values done");

        // Select is still a preset shape here, so these writes never reach the RAM.
        wr(ra(1, OFF_CTRL), 8'hff, RESP_OKAY);
        rd(ra(1, OFF_CTRL), 8'h7f, RESP_OKAY);
        wr(ra(1, OFF_SAMPLE), 8'hff, RESP_OKAY);
        rd(ra(1, OFF_SAMPLE), 8'h7f, RESP_OKAY);
        $display("Test reserved_bit done");

        for (int c = 0; c < NUM_CH; c++) begin
            // Nonzero index values keep channel 0 distinguishable from its reset value.
            wr(ra(c, OFF_CTRL), 8'(c + 16), RESP_OKAY);
            wr(ra(c, OFF_SAMPLE), 8'(c + 32), RESP_OKAY);
        end
        for (int c = 0; c < NUM_CH; c++) begin
            rd(ra(c, OFF_CTRL), 8'(c + 16), RESP_OKAY);
            rd(ra(c, OFF_SAMPLE), 8'(c + 32), RESP_OKAY);
        end
        $display("Test channel_map done");

        wr(ra(1, OFF_PULSE), 8'h08, RESP_OKAY);
        wr(ra(1, OFF_SAMPLE), 8'h55, RESP_OKAY);
        wr(ra(1, OFF_CTRL), 8'h45, RESP_OKAY);
        wr(ra(1, OFF_CTRL), 8'h65, RESP_OKAY);
        wr(ra(1, OFF_SAMPLE), 8'h2a, RESP_OKAY);
        rd(ra(1, OFF_SAMPLE), 8'h55, RESP_OKAY);
        wr(ra(1, OFF_CTRL), 8'h05, RESP_OKAY);
        rd(ra(1, OFF_SAMPLE), 8'h2a, RESP_OKAY);
        wr(ra(1, OFF_CTRL), 8'h65, RESP_OKAY);
        rd(ra(1, OFF_SAMPLE), 8'h55, RESP_OKAY);
        $display("Test ram_access done");

        // A control write in write mode also stores the held sample, so each entry gets its final value last.
        wr(ra(1, OFF_CTRL), 8'h52, RESP_OKAY);
        wr(ra(1, OFF_SAMPLE), 8'h33, RESP_OKAY);
        wr(ra(1, OFF_CTRL), 8'h59, RESP_OKAY);
        wr(ra(1, OFF_SAMPLE), 8'h11, RESP_OKAY);
        wr(ra(1, OFF_CTRL), 8'h73, RESP_OKAY);
        rd(ra(1, OFF_SAMPLE), 8'h11, RESP_OKAY);
        wr(ra(1, OFF_CTRL), 8'h7f, RESP_OKAY);
        rd(ra(1, OFF_SAMPLE), 8'h11, RESP_OKAY);
        wr(ra(1, OFF_CTRL), 8'h72, RESP_OKAY);
        rd(ra(1, OFF_SAMPLE), 8'h33, RESP_OKAY);
        $display("Test index_fold done");

        wr(ra(1, OFF_PULSE), 8'h07, RESP_OKAY);
        wr(ra(1, OFF_SAMPLE), 8'h44, RESP_OKAY);
        wr(ra(1, OFF_CTRL), 8'h45, RESP_OKAY);
        wr(ra(1, OFF_CTRL), 8'h65, RESP_OKAY);
        rd(ra(1, OFF_SAMPLE), 8'h44, RESP_OKAY);
        for (int s = 8; s < 16; s++) begin
            wr(ra(1, OFF_PULSE), 8'(s), RESP_OKAY);
            rd(ra(1, OFF_SAMPLE), 8'h55, RESP_OKAY);
        end
        wr(ra(2, OFF_PULSE), 8'h08, RESP_OKAY);
        wr(ra(2, OFF_CTRL), 8'h65, RESP_OKAY);
        rd(ra(2, OFF_SAMPLE), 8'h00, RESP_OKAY);
        $display("Test select_gating done");

        wr(13'h0f20, 8'h45, RESP_SLVERR);
        rd(13'h0f20, 8'h00, RESP_SLVERR);
        wr(ra(1, 6'h07), 8'h12, RESP_SLVERR);
        rd(ra(1, 6'h07), 8'h00, RESP_SLVERR);
        rd(ra(1, OFF_SAMPLE), 8'h55, RESP_OKAY);
        $display("Test unmapped done");

        print_verdict();
    end
endmodule // test_waveform_template_ram_access

// ---- verilog/template_ram.sv ----
// Per-channel template sample RAM: one write port, one combinational read port.
`timescale 1ns/100ps
module template_ram (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Access port
    wavram_if.ram     bus
);
    import wavram_pkg::*;

    logic [SAMP_W-1:0] mem [NUM_CH][RAM_DEPTH];

    // Clearing on reset keeps read-back defined before software loads a template.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                for (int e = 0; e < RAM_DEPTH; e++) begin
                    mem[c][e] <= '0;
                end
            end
        end else if (bus.we) begin
            mem[bus.wr_ch][bus.wr_entry] <= bus.wr_data;
        end
    end

    assign bus.rd_data = mem[bus.rd_ch][bus.rd_entry];

endmodule // template_ram

// ---- verilog/waveform_template_ram_access.sv ----
// AXI4-Lite register bank giving software access to the transmit template RAMs.
`timescale 1ns/100ps

// Functional notes
// - The access enable bit of the control register must be set for any RAM access.
// - The direction bit selects a RAM write when 0 and a RAM read when 1.
// - Sample indices 0 to 19 address entries directly and 20 to 31 all address entry 19.
// - The waveform fields only act while the template select has its top bit set.
// - A write access stores the seven-bit sample value into the indexed RAM entry.
// - The stored sample value changes only when software writes a new one.
// - Both waveform registers reset to zero and read bit 7 as zero.
// - Each channel has its own registers, channels 1-15 from 008h in 40h steps, 0 at 7c8h.
// - Template select values with the top bit set choose the programmable waveform.
module waveform_template_ram_access (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // AXI4-Lite write address
    input  wire logic [wavram_pkg::ADDR_W-1:0] awaddr_i,
    input  wire logic                       awvalid_i,
    output logic                            awready_o,
    // AXI4-Lite write data
    input  wire logic [31:0]                wdata_i,
    input  wire logic [3:0]                 wstrb_i,
    input  wire logic                       wvalid_i,
    output logic                            wready_o,
    // AXI4-Lite write response
    output logic [1:0]                      bresp_o,
    output logic                            bvalid_o,
    input  wire logic                       bready_i,
    // AXI4-Lite read address
    input  wire logic [wavram_pkg::ADDR_W-1:0] araddr_i,
    input  wire logic                       arvalid_i,
    output logic                            arready_o,
    // AXI4-Lite read data
    output logic [31:0]                     rdata_o,
    output logic [1:0]                      rresp_o,
    output logic                            rvalid_o,
    input  wire logic                       rready_i
);
    import wavram_pkg::*;

    // Per-channel register state, plus the pending RAM write flag and its channel.
    logic [NUM_CH-1:0][SAMP_W-1:0] ctrl_q,   ctrl_d;
    logic [NUM_CH-1:0][SAMP_W-1:0] samp_q,   samp_d;
    logic [NUM_CH-1:0][3:0]        puls_q,   puls_d;
    logic                          pend_q,   pend_d;
    logic [3:0]                    pend_ch_q, pend_ch_d;

    // Write channel state.
    wr_state_t                     wr_state_q, wr_state_d;
    logic                          aw_held_q, aw_held_d;
    logic                          w_held_q,  w_held_d;
    logic [ADDR_W-1:0]             waddr_q,   waddr_d;
    logic [31:0]                   wdata_q,   wdata_d;
    logic [3:0]                    wstrb_q,   wstrb_d;
    logic                          awready_q, awready_d;
    logic                          wready_q,  wready_d;
    logic                          bvalid_q,  bvalid_d;
    logic [1:0]                    bresp_q,   bresp_d;

    // Read channel state.
    rd_state_t                     rd_state_q, rd_state_d;
    logic                          arready_q, arready_d;
    logic                          rvalid_q,  rvalid_d;
    logic [1:0]                    rresp_q,   rresp_d;
    logic [31:0]                   rdata_q,   rdata_d;

    logic                          aw_take;
    logic                          w_take;
    logic                          ar_take;
    logic                          do_write;
    reg_hit_t                      wr_hit;
    reg_hit_t                      rd_hit;
    logic [7:0]                    rd_byte;

    wavram_if ram_bus ();

    template_ram i_template_ram (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .bus   (ram_bus.ram)
    );

    function automatic logic arb_selected(input logic [3:0] puls);
        return puls[PULS_ARB_BIT];
    endfunction

    function automatic logic access_on(input logic [SAMP_W-1:0] ctrl, input logic [3:0] puls,
                                       input logic rd);
        return ctrl[CTRL_EN_BIT] && arb_selected(puls) && (ctrl[CTRL_DIR_BIT] == rd);
    endfunction

    assign aw_take  = awvalid_i && awready_q;
    assign w_take   = wvalid_i && wready_q;
    assign ar_take  = arvalid_i && arready_q;
    assign do_write = aw_held_q && w_held_q && (wr_state_q == WR_COLLECT);
    assign wr_hit   = decode_addr(waddr_q);
    assign rd_hit   = decode_addr(araddr_i);

    // A RAM write follows one cycle after any register write to the channel, so it always
    // uses the settled index and sample value, whichever register software wrote last.
    assign ram_bus.we       = pend_q && access_on(ctrl_q[pend_ch_q], puls_q[pend_ch_q], 1'b0);
    assign ram_bus.wr_ch    = pend_ch_q;
    assign ram_bus.wr_entry = ram_entry(ctrl_q[pend_ch_q][IDX_MSB:0]);
    assign ram_bus.wr_data  = samp_q[pend_ch_q];
    assign ram_bus.rd_ch    = rd_hit.ch;
    assign ram_bus.rd_entry = ram_entry(ctrl_q[rd_hit.ch][IDX_MSB:0]);

    // Write address and data are collected in either order, then applied together.
    always_comb begin
        wr_state_d = wr_state_q;
        aw_held_d  = aw_held_q || aw_take;
        w_held_d   = w_held_q || w_take;
        waddr_d    = aw_take ? awaddr_i : waddr_q;
        wdata_d    = w_take ? wdata_i : wdata_q;
        wstrb_d    = w_take ? wstrb_i : wstrb_q;
        bvalid_d   = bvalid_q;
        bresp_d    = bresp_q;
        case (wr_state_q)
            WR_COLLECT: begin
                if (do_write) begin
                    aw_held_d  = 1'b0;
                    w_held_d   = 1'b0;
                    bvalid_d   = 1'b1;
                    bresp_d    = wr_hit.hit ? RESP_OKAY : RESP_SLVERR;
                    wr_state_d = WR_RESP;
                end
            end
            WR_RESP: begin
                if (bready_i) begin
                    bvalid_d   = 1'b0;
                    wr_state_d = WR_COLLECT;
                end
            end
            default: begin
                wr_state_d = WR_COLLECT;
                bvalid_d   = 1'b0;
            end
        endcase
        awready_d = !aw_held_d && (wr_state_d == WR_COLLECT);
        wready_d  = !w_held_d && (wr_state_d == WR_COLLECT);
    end

    // Register file; only the low byte lane carries data, so a write without it is dropped.
    always_comb begin
        ctrl_d    = ctrl_q;
        samp_d    = samp_q;
        puls_d    = puls_q;
        pend_d    = 1'b0;
        pend_ch_d = pend_ch_q;
        if (do_write && wr_hit.hit && wstrb_q[0]) begin
            pend_d    = 1'b1;
            pend_ch_d = wr_hit.ch;
            case (wr_hit.sel)
                REG_PULSE:  puls_d[wr_hit.ch] = wdata_q[3:0];
                REG_CTRL:   ctrl_d[wr_hit.ch] = wdata_q[SAMP_W-1:0];
                REG_SAMPLE: samp_d[wr_hit.ch] = wdata_q[SAMP_W-1:0];
                default: ;
            endcase
        end
    end

    // Read mux: the sample register shows the RAM entry while a read access is set up.
    always_comb begin
        case (rd_hit.sel)
            REG_PULSE:  rd_byte = {4'h0, puls_q[rd_hit.ch]};
            REG_CTRL:   rd_byte = {1'b0, ctrl_q[rd_hit.ch]};
            REG_SAMPLE: begin
                if (access_on(ctrl_q[rd_hit.ch], puls_q[rd_hit.ch], 1'b1)) begin
                    rd_byte = {1'b0, ram_bus.rd_data};
                end else begin
                    rd_byte = {1'b0, samp_q[rd_hit.ch]};
                end
            end
            default:    rd_byte = 8'h00;
        endcase
        if (!rd_hit.hit) begin
            rd_byte = 8'h00;
        end
    end

    always_comb begin
        rd_state_d = rd_state_q;
        rvalid_d   = rvalid_q;
        rresp_d    = rresp_q;
        rdata_d    = rdata_q;
        case (rd_state_q)
            RD_IDLE: begin
                if (ar_take) begin
                    rvalid_d   = 1'b1;
                    rresp_d    = rd_hit.hit ? RESP_OKAY : RESP_SLVERR;
                    rdata_d    = {24'h000000, rd_byte};
                    rd_state_d = RD_RESP;
                end
            end
            RD_RESP: begin
                if (rready_i) begin
                    rvalid_d   = 1'b0;
                    rd_state_d = RD_IDLE;
                end
            end
            default: begin
                rvalid_d   = 1'b0;
                rd_state_d = RD_IDLE;
            end
        endcase
        arready_d = (rd_state_d == RD_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q     <= {NUM_CH{CTRL_RST}};
            samp_q     <= {NUM_CH{SAMPLE_RST}};
            puls_q     <= {NUM_CH{PULS_RST}};
            pend_q     <= 1'b0;
            pend_ch_q  <= 4'h0;
            wr_state_q <= WR_COLLECT;
            aw_held_q  <= 1'b0;
            w_held_q   <= 1'b0;
            waddr_q    <= '0;
            wdata_q    <= 32'h00000000;
            wstrb_q    <= 4'h0;
            awready_q  <= 1'b0;
            wready_q   <= 1'b0;
            bvalid_q   <= 1'b0;
            bresp_q    <= RESP_OKAY;
            rd_state_q <= RD_IDLE;
            arready_q  <= 1'b0;
            rvalid_q   <= 1'b0;
            rresp_q    <= RESP_OKAY;
            rdata_q    <= 32'h00000000;
        end else begin
            ctrl_q     <= ctrl_d;
            samp_q     <= samp_d;
            puls_q     <= puls_d;
            pend_q     <= pend_d;
            pend_ch_q  <= pend_ch_d;
            wr_state_q <= wr_state_d;
            aw_held_q  <= aw_held_d;
            w_held_q   <= w_held_d;
            waddr_q    <= waddr_d;
            wdata_q    <= wdata_d;
            wstrb_q    <= wstrb_d;
            awready_q  <= awready_d;
            wready_q   <= wready_d;
            bvalid_q   <= bvalid_d;
            bresp_q    <= bresp_d;
            rd_state_q <= rd_state_d;
            arready_q  <= arready_d;
            rvalid_q   <= rvalid_d;
            rresp_q    <= rresp_d;
            rdata_q    <= rdata_d;
        end
    end

    assign awready_o = awready_q;
    assign wready_o  = wready_q;
    assign bvalid_o  = bvalid_q;
    assign bresp_o   = bresp_q;
    assign arready_o = arready_q;
    assign rvalid_o  = rvalid_q;
    assign rresp_o   = rresp_q;
    assign rdata_o   = rdata_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence sample_write_s;
        do_write && wr_hit.hit && wstrb_q[0] && (wr_hit.sel == REG_SAMPLE)
            && access_on(ctrl_q[wr_hit.ch], puls_q[wr_hit.ch], 1'b0);
    endsequence

    // The store is one-shot in the cycle right after the register update, so the RAM port
    // must carry the word that was on the internal write data one cycle earlier.
    sequence ram_store_s;
        ram_bus.we && (ram_bus.wr_data == $past(wdata_q[SAMP_W-1:0]));
    endsequence

    chk_access_enable_gate: assert property (
        ram_bus.we |-> ctrl_q[pend_ch_q][CTRL_EN_BIT] && $past(pend_d))
        else $error("RAM written while access is disabled");

    chk_direction_write: assert property (
        pend_q && ctrl_q[pend_ch_q][CTRL_DIR_BIT] |-> !ram_bus.we)
        else $error("RAM written while direction selects read");

    chk_entry_fold: assert property (
        ram_bus.we && (ctrl_q[pend_ch_q][IDX_MSB:0] >= LAST_ENTRY) |-> ram_bus.wr_entry == LAST_ENTRY)
        else $error("High sample index not folded onto last entry");

    chk_template_gate: assert property (
        pend_q && !puls_q[pend_ch_q][PULS_ARB_BIT] |-> !ram_bus.we)
        else $error("RAM written with a preset template selected");

    chk_sample_lands: assert property (
        sample_write_s |=> ram_store_s)
        else $error("Sample value write did not reach the RAM");

    chk_sample_holds: assert property (
        !(do_write && wr_hit.sel == REG_SAMPLE) |=> $stable(samp_q))
        else $error("Sample value changed without a software write");

    chk_reset_zero: assert property (
        $past(rst_i) |-> (ctrl_q == '0) && (samp_q == '0) && (rdata_q == 32'h00000000))
        else $error("Waveform registers not zero after reset");

    chk_ch0_placement: assert property (
        do_write && wstrb_q[0] && (waddr_q[12:2] == {CH0_BLOCK, OFF_CTRL})
            |=> ctrl_q[0] == $past(wdata_q[SAMP_W-1:0]))
        else $error("Channel 0 control register not at its block");

    chk_preset_blocks: assert property (
        pend_q && (puls_q[pend_ch_q] < 4'h8) |-> !ram_bus.we)
        else $error("Preset template value opened RAM access");

    chk_read_returns_ram: assert property (
        ar_take && rd_hit.hit && (rd_hit.sel == REG_SAMPLE)
            && access_on(ctrl_q[rd_hit.ch], puls_q[rd_hit.ch], 1'b1)
            |=> rvalid_o && (rdata_o[SAMP_W-1:0] == $past(ram_bus.rd_data)) && !rdata_o[7])
        else $error("Read access did not return the RAM entry");

    chk_write_answer: assert property (
        do_write |=> bvalid_o && !awready_o && !wready_o)
        else $error("Write response not raised after address and data");

endmodule // waveform_template_ram_access

// ---- verilog/wavram_if.sv ----
// Port bundle between the register bank and the template sample RAM.
`timescale 1ns/100ps
interface wavram_if;
    import wavram_pkg::*;
    logic                 we;
    logic [3:0]           wr_ch;
    logic [IDX_W-1:0]     wr_entry;
    logic [SAMP_W-1:0]    wr_data;
    logic [3:0]           rd_ch;
    logic [IDX_W-1:0]     rd_entry;
    logic [SAMP_W-1:0]    rd_data;

    modport ctrl (output we, wr_ch, wr_entry, wr_data, rd_ch, rd_entry, input rd_data);
    modport ram  (input we, wr_ch, wr_entry, wr_data, rd_ch, rd_entry, output rd_data);
endinterface

// ---- verilog/wavram_pkg.sv ----
// Constants, types and decode helpers for the waveform template RAM access block.
package wavram_pkg;

    localparam int          NUM_CH        = 16;
    localparam int          SAMP_W        = 7;
    localparam int          IDX_W         = 5;
    localparam int          RAM_DEPTH     = 20;
    localparam int          ADDR_W        = 13;

    // Register indices within one channel block (byte address is four times the index).
    localparam logic [5:0]  OFF_PULSE     = 6'h06;
    localparam logic [5:0]  OFF_CTRL      = 6'h08;
    localparam logic [5:0]  OFF_SAMPLE    = 6'h09;
    // Channel blocks are 0x40 indices apart; channel 0 sits in block 0x1f (index 7c0h).
    localparam logic [4:0]  CH0_BLOCK     = 5'h1f;
    localparam logic [4:0]  LAST_CH_BLOCK = 5'h0e;

    // Field positions.
    localparam int          CTRL_EN_BIT   = 6;
    localparam int          CTRL_DIR_BIT  = 5;
    localparam int          IDX_MSB       = 4;
    localparam int          PULS_ARB_BIT  = 3;

    // Reset values.
    localparam logic [6:0]  CTRL_RST      = 7'h00;
    localparam logic [6:0]  SAMPLE_RST    = 7'h00;
    localparam logic [3:0]  PULS_RST      = 4'h2;

    // Highest RAM entry; larger indices fold onto it.
    localparam logic [4:0]  LAST_ENTRY    = 5'h13;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        REG_NONE   = 2'h0,
        REG_PULSE  = 2'h1,
        REG_CTRL   = 2'h2,
        REG_SAMPLE = 2'h3
    } reg_sel_t;

    typedef struct packed {
        logic     hit;
        logic [3:0] ch;
        reg_sel_t sel;
    } reg_hit_t;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP    = 2'b10
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_t;

    function automatic reg_hit_t decode_addr(input logic [ADDR_W-1:0] addr);
        reg_hit_t   r;
        logic [4:0] blk;
        logic [5:0] off;
        logic       ok;
        r   = '0;
        blk = addr[12:8];
        off = addr[7:2];
        ok  = 1'b1;
        if (blk == CH0_BLOCK) begin
            r.ch = 4'h0;
        end else if (blk <= LAST_CH_BLOCK) begin
            r.ch = blk[3:0] + 4'h1;
        end else begin
            ok = 1'b0;
        end
        case (off)
            OFF_PULSE:  r.sel = REG_PULSE;
            OFF_CTRL:   r.sel = REG_CTRL;
            OFF_SAMPLE: r.sel = REG_SAMPLE;
            default:    r.sel = REG_NONE;
        endcase
        r.hit = ok && (r.sel != REG_NONE);
        return r;
    endfunction

    function automatic logic [IDX_W-1:0] ram_entry(input logic [IDX_W-1:0] idx);
        return (idx > LAST_ENTRY) ? LAST_ENTRY : idx;
    endfunction

endpackage
